// File: nand_host_pkg.sv
// Constants and types shared by the NAND pin-level host controller
package nand_host_pkg;
    localparam int BUS_W = 8;                 // Shared pin bus width
    localparam logic [7:0] CMD_RESET = 8'hFF; // Reset command byte
    localparam int PAGE_BYTES = 2176;         // Main plus spare
    localparam int PAGE_MAIN = 2048;          // Main area size
    localparam int PAGE_SPARE = 128;          // Spare area size
    localparam int BLOCK_PAGES = 64;          // Pages per erase block
    localparam int PLANE_BLOCKS = 1024;       // Blocks per plane
    localparam int PLANE_COUNT = 2;           // Planes per die
    localparam int PAGE_BITS = 6;             // Page-in-block field width
    localparam int BLOCK_BITS = 11;           // Block field width
    localparam int ROW_BITS = PAGE_BITS + BLOCK_BITS;
    localparam int FIFO_DEPTH = 8;            // Read data buffer depth
    // Pin timing: strobe low and high phases, nanoseconds
    localparam int STROBE_LOW_NS = 12;
    localparam int STROBE_HIGH_NS = 10;
    localparam int CLK_NS = 4;                // sys_clk period
    // Least times round up to whole cycles
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] LOW_CNT = 4'(STROBE_LOW_CYC - 1);
    localparam logic [3:0] HIGH_CNT = 4'(STROBE_HIGH_CYC - 1);
    localparam logic [3:0] BLANK_CNT = 4'hF; // Cycles before ready/busy is trusted

    // Kind of cycle the user asks for
    typedef enum logic [1:0] {
        OP_CMD  = 2'b00,
        OP_ADDR = 2'b01,
        OP_WDATA = 2'b10,
        OP_RDATA = 2'b11
    } op_kind_t;

    // Cycle engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b011,
        ST_BUSYWAIT = 3'b100
    } cyc_state_t;

    // Plane of a row address: lowest block bit
    function automatic logic row_plane(input logic [ROW_BITS-1:0] row);
        return row[PAGE_BITS];
    endfunction : row_plane
endpackage : nand_host_pkg

// File: host_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
module host_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];   // Storage words
    logic [AW-1:0] wr_q, wr_d;         // Write pointer
    logic [AW-1:0] rd_q, rd_d;         // Read pointer
    logic [AW:0] cnt_q, cnt_d;         // Fill level
    logic push, pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and level update
    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Register pointers; storage has no reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule : host_fifo

// File: nand_host_ctrl.sv
// NAND host controller: drives the flash pins one bus cycle per user request
module nand_host_ctrl
    import nand_host_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    // User request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_kind,
    input wire logic [7:0] req_data,
    input wire logic req_wait_ready,
    input wire logic write_protect_n,
    // Read data side
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready,
    // Status
    output logic dev_busy,
    output logic reset_done,
    output logic cmd_refused,
    // Flash pins
    output logic chip_en_n,
    output logic cmd_latch,
    output logic addr_latch,
    output logic write_en_n,
    output logic read_en_n,
    output logic wp_n,
    output logic [7:0] io_out,
    output logic io_oe_n,
    input wire logic [7:0] io_in,
    input wire logic ready_busy_n
);
    cyc_state_t st_q, st_d;            // Cycle engine state
    logic [3:0] tmr_q, tmr_d;          // Phase timer
    op_kind_t kind_q, kind_d;          // Kind of cycle in flight
    logic [7:0] byte_q, byte_d;        // Byte being driven
    logic wait_q, wait_d;              // Wait for ready after cycle
    logic ce_n_q, ce_n_d;
    logic cle_q, cle_d;
    logic ale_q, ale_d;
    logic we_n_q, we_n_d;
    logic re_n_q, re_n_d;
    logic oe_n_q, oe_n_d;
    logic wp_n_q;
    logic init_q, init_d;              // Reset command already sent
    logic refused_q, refused_d;        // Request refused before reset
    logic busy_q;                      // Synchronised busy view
    logic [1:0] rb_sync_q;             // Ready/busy synchroniser
    logic [7:0] io_s1_q, io_s2_q;      // Bus input synchroniser
    logic fifo_in_ready, fifo_push;
    logic [7:0] fifo_out;
    logic fifo_ov;
    logic rd_valid_q;
    logic [7:0] rd_data_q;
    logic rd_valid_d;                  // Skid stage next valid
    logic [7:0] rd_data_d;             // Skid stage next byte
    logic rd_take;                     // Skid stage empty or being emptied
    logic req_ready_q;                 // Engine idle, registered

    // Pins from outside pass two flops before use
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rb_sync_q <= 2'h0;
            io_s1_q <= 8'h00;
            io_s2_q <= 8'h00;
        end else begin
            rb_sync_q <= {rb_sync_q[0], ~ready_busy_n}; // Stored as busy, so output is a flop
            io_s1_q <= io_in;
            io_s2_q <= io_s1_q;
        end
    end
    assign busy_q = rb_sync_q[1]; // Low pin level means busy

    // Read bytes are captured in the last cycle of the strobe high phase; the FIFO stalls the engine
    assign fifo_push = (st_q == ST_HIGH) && (kind_q == OP_RDATA) && (tmr_q == HIGH_CNT);

    host_fifo #(.WIDTH(BUS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_data(io_s2_q),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_ov),
        .out_ready(rd_take)
    );

    // Cycle engine next state
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q;
        kind_d = kind_q;
        byte_d = byte_q;
        wait_d = wait_q;
        ce_n_d = ce_n_q;
        cle_d = cle_q;
        ale_d = ale_q;
        we_n_d = we_n_q;
        re_n_d = re_n_q;
        oe_n_d = oe_n_q;
        init_d = init_q;
        refused_d = 1'b0;
        case (st_q)
            ST_IDLE: begin
                ce_n_d = 1'b1; // Release enable when idle; standby while ready
                cle_d = 1'b0;
                ale_d = 1'b0;
                oe_n_d = 1'b1;
                if (req_valid) begin
                    // First command must be the reset byte
                    if (!init_q && !(req_kind == OP_CMD && req_data == CMD_RESET)) begin
                        refused_d = 1'b1;
                    end else begin
                        if (req_kind == OP_CMD && req_data == CMD_RESET) begin
                            init_d = 1'b1;
                        end
                        // Bytes pass unchanged; plane limits stay with the user
                        kind_d = op_kind_t'(req_kind);
                        byte_d = req_data;
                        wait_d = req_wait_ready;
                        ce_n_d = 1'b0;
                        cle_d = (req_kind == OP_CMD);   // Command cycle
                        ale_d = (req_kind == OP_ADDR);  // Address cycle
                        // Drive the shared bus except on reads
                        oe_n_d = (req_kind == OP_RDATA);
                        tmr_d = 4'h0;
                        st_d = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                // Reads wait for room so no byte is lost
                if (kind_q != OP_RDATA || fifo_in_ready) begin
                    if (kind_q == OP_RDATA) begin
                        re_n_d = 1'b0; // Falling read strobe advances column
                    end else begin
                        we_n_d = 1'b0;
                    end
                    tmr_d = 4'h0;
                    st_d = ST_LOW;
                end
            end
            ST_LOW: begin
                tmr_d = tmr_q + 4'h1;
                if (tmr_q == LOW_CNT) begin
                    we_n_d = 1'b1; // Rising write strobe latches the byte
                    re_n_d = 1'b1;
                    tmr_d = 4'h0;
                    st_d = ST_HIGH;
                end
            end
            ST_HIGH: begin
                tmr_d = tmr_q + 4'h1;
                if (tmr_q == HIGH_CNT) begin
                    cle_d = 1'b0;
                    ale_d = 1'b0;
                    tmr_d = 4'h0;
                    st_d = wait_q ? ST_BUSYWAIT : ST_IDLE;
                end
            end
            ST_BUSYWAIT: begin
                // Allow busy to assert, then hold until released
                tmr_d = (tmr_q == BLANK_CNT) ? tmr_q : tmr_q + 4'h1;
                if (tmr_q == BLANK_CNT && !busy_q) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Register engine state
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= ST_IDLE;
            tmr_q <= 4'h0;
            kind_q <= OP_CMD;
            byte_q <= 8'h00;
            wait_q <= 1'b0;
            ce_n_q <= 1'b1;
            cle_q <= 1'b0;
            ale_q <= 1'b0;
            we_n_q <= 1'b1;
            re_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            init_q <= 1'b0;
            refused_q <= 1'b0;
            wp_n_q <= 1'b0;
            req_ready_q <= 1'b1;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            kind_q <= kind_d;
            byte_q <= byte_d;
            wait_q <= wait_d;
            ce_n_q <= ce_n_d;
            cle_q <= cle_d;
            ale_q <= ale_d;
            we_n_q <= we_n_d;
            re_n_q <= re_n_d;
            oe_n_q <= oe_n_d;
            init_q <= init_d;
            refused_q <= refused_d;
            wp_n_q <= write_protect_n; // Low blocks program and erase
            req_ready_q <= (st_d == ST_IDLE); // Same cycle as IDLE, but from a flop
        end
    end

    // Output stage load and FIFO pop share one enable, so no byte is shown twice
    assign rd_take = !rd_valid_q || rd_ready;

    // Output stage next value
    always_comb begin
        rd_valid_d = rd_valid_q;
        rd_data_d = rd_data_q;
        if (rd_take) begin
            rd_valid_d = fifo_ov;
            rd_data_d = fifo_out;
        end
    end

    // Register output stage
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= 8'h00;
        end else begin
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
        end
    end

    assign req_ready = req_ready_q;
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign dev_busy = busy_q;
    assign reset_done = init_q;
    assign cmd_refused = refused_q;
    assign chip_en_n = ce_n_q;
    assign cmd_latch = cle_q;
    assign addr_latch = ale_q;
    assign write_en_n = we_n_q;
    assign read_en_n = re_n_q;
    assign wp_n = wp_n_q;
    assign io_out = byte_q;
    assign io_oe_n = oe_n_q;
endmodule : nand_host_ctrl

// File: nand_host_ctrl_chk.sv
// Port checks for the NAND host controller
module nand_host_ctrl_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [1:0] req_kind,
    input wire logic [7:0] req_data,
    input wire logic write_protect_n,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire logic reset_done,
    input wire logic cmd_refused,
    input wire logic chip_en_n,
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic write_en_n,
    input wire logic read_en_n,
    input wire logic wp_n,
    input wire logic io_oe_n
);
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    property p_refuse; req_valid && req_ready && !reset_done && !(req_kind == 2'b00 && req_data == 8'hFF) |=> cmd_refused; endproperty
    a_refuse: assert property (p_refuse) else $error("early request not refused");
    property p_excl; !(cmd_latch && addr_latch); endproperty
    a_excl: assert property (p_excl) else $error("both latch enables high");
    property p_wlow; $fell(write_en_n) |-> !write_en_n [*3] ##1 write_en_n; endproperty
    a_wlow: assert property (p_wlow) else $error("write strobe width wrong");
    property p_wbus; !write_en_n |-> $stable(cmd_latch) && $stable(addr_latch) && !io_oe_n; endproperty
    a_wbus: assert property (p_wbus) else $error("bus moved under write strobe");
    property p_rbus; !read_en_n |-> io_oe_n && !cmd_latch && !addr_latch; endproperty
    a_rbus: assert property (p_rbus) else $error("host drives bus during read");
    property p_ce; !write_en_n || !read_en_n |-> !chip_en_n; endproperty
    a_ce: assert property (p_ce) else $error("strobe without chip enable");
    property p_wp; !$past(reset) |-> wp_n == $past(write_protect_n); endproperty
    a_wp: assert property (p_wp) else $error("protect pin not following");
    property p_hold; rd_valid && !rd_ready |=> rd_valid && $stable(rd_data); endproperty
    a_hold: assert property (p_hold) else $error("read byte lost while stalled");
    // Main scenarios are reached
    c_refuse: cover property (cmd_refused);
    c_stall: cover property (rd_valid && !rd_ready);
    c_read: cover property ($fell(read_en_n));
endmodule : nand_host_ctrl_chk
bind nand_host_ctrl nand_host_ctrl_chk i_chk (.sys_clk, .reset, .req_valid, .req_ready, .req_kind,
    .req_data, .write_protect_n, .rd_data, .rd_valid, .rd_ready, .reset_done, .cmd_refused,
    .chip_en_n, .cmd_latch, .addr_latch, .write_en_n, .read_en_n, .wp_n, .io_oe_n);

// File: nand_dev_model.sv
// Behavioural flash device answering the controller pins
module nand_dev_model #(
    parameter int BUSY_CYC = 40 // Array time, kept short for the run
) (
    input wire logic sys_clk,
    input wire logic chip_en_n,
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic write_en_n,
    input wire logic read_en_n,
    input wire logic wp_n,
    input wire logic [7:0] io_out,
    input wire logic io_oe_n,
    output logic [7:0] io_in,
    output logic ready_busy_n
);
    logic [11:0] col = 12'h000; // Column, main 2048 then spare 128
    logic [16:0] row = 17'h00000; // Block joined with page
    logic plane_select_row_bit; // Plane the row points at
    assign plane_select_row_bit = nand_host_pkg::row_plane(row);
    logic [7:0] dout = 8'h00; // Last byte put out
    logic drv = 1'b0; // Device drives the bus
    int acnt = 0; // Address cycle index
    int busy = 0; // Busy cycles left, chip enable has no say; one die alone
    // Bytes are taken on the write strobe rise
    always @(posedge write_en_n) begin
        if (chip_en_n === 1'b0 && cmd_latch === 1'b1) begin
            acnt = 0;
            if (io_out == 8'h30 || io_out == 8'hFF) busy = BUSY_CYC;
            if ((io_out == 8'h10 || io_out == 8'hD0) && wp_n) busy = BUSY_CYC;
        end else if (chip_en_n === 1'b0 && addr_latch === 1'b1) begin
            if (acnt == 0) col[7:0] = io_out;
            if (acnt == 1) col[11:8] = io_out[3:0];
            if (acnt == 2) row[7:0] = io_out; // 64 pages, then low block bits
            if (acnt == 3) row[15:8] = io_out;
            if (acnt == 4) row[16] = io_out[0]; // Top block bit of 11, 2048 blocks; plane is the lowest block bit
            acnt++;
        end
    end
    // Read strobe fall puts out a byte and steps the column
    always @(negedge read_en_n) begin
        if (chip_en_n === 1'b0) begin
            dout = col[7:0] ^ 8'h5A ^ {7'h00, plane_select_row_bit}; // Plane marks data
            col++;
            drv = 1'b1;
        end
    end
    // Output is held until chip enable rises, as real parts keep it
    always @(posedge chip_en_n) drv = 1'b0;
    // Array time runs down, then the pull-up wins
    always @(posedge sys_clk) if (busy > 0) busy--;
    assign ready_busy_n = (busy == 0);
    // Host drive wins; a released bus shows the inverse of the last byte
    assign io_in = !io_oe_n ? io_out : drv ? dout : ~dout;
endmodule : nand_dev_model

// File: nand_host_ctrl_tb_top.sv
// Self-checking bench: controller against the flash device model
module nand_host_ctrl_tb_top;
    import nand_host_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0, req_wait_ready = 1'b0, write_protect_n = 1'b0, rd_ready = 1'b1;
    logic [1:0] req_kind = 2'h0;
    logic [7:0] req_data = 8'h00;
    logic req_ready, rd_valid, dev_busy, reset_done, cmd_refused, wp_n, io_oe_n, ready_busy_n;
    logic chip_en_n, cmd_latch, addr_latch, write_en_n, read_en_n;
    logic busy_seen = 1'b0; // Device went busy since last cleared
    logic [7:0] rd_data, io_out, io_in;
    int bad_count = 0;
    int checks_done = 0;
    int takes = 0; // Requests accepted
    int got = 0; // Read bytes delivered
    always #2 sys_clk = ~sys_clk;
    nand_host_ctrl i_dut (.sys_clk, .reset, .req_valid, .req_ready, .req_kind, .req_data,
        .req_wait_ready, .write_protect_n, .rd_data, .rd_valid, .rd_ready, .dev_busy, .reset_done,
        .cmd_refused, .chip_en_n, .cmd_latch, .addr_latch, .write_en_n, .read_en_n, .wp_n,
        .io_out, .io_oe_n, .io_in, .ready_busy_n);
    nand_dev_model i_dev (.sys_clk, .chip_en_n, .cmd_latch, .addr_latch, .write_en_n,
        .read_en_n, .wp_n, .io_out, .io_oe_n, .io_in, .ready_busy_n);
    // Watch settled values mid-cycle, ahead of the edge that acts on them
    always @(negedge sys_clk) begin
        if (req_valid && req_ready) takes++;
        if (dev_busy) busy_seen = 1'b1;
        if (rd_valid && rd_ready) begin
            check("rd_data", 8'(8'hFE + got) ^ 8'h5B, rd_data);
            got++;
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    // Bounded wait for the controller to go idle
    task automatic wait_rdy;
        for (int i = 0; req_ready !== 1'b1; i++) begin
            if (i == 600) begin
                bad_count++;
                end_sim();
            end
            step(1);
        end
    endtask : wait_rdy
    // One request, held until taken; the gap edge keeps strobes clean
    task automatic send(input logic [1:0] k, input logic [7:0] d, input logic w = 1'b0);
        step(1);
        req_kind = k;
        req_data = d;
        req_wait_ready = w;
        req_valid = 1'b1;
        wait_rdy();
        step(1);
        req_valid = 1'b0;
    endtask : send
    // Anything before the reset command is dropped
    task automatic t_first;
        send(OP_ADDR, 8'h00);
        check("refused", 8'h01, 8'(cmd_refused));
        check("ready_after_refuse", 8'h01, 8'(req_ready));
        check("reset_done_early", 8'h00, 8'(reset_done));
        send(OP_CMD, CMD_RESET, 1'b1);
        wait_rdy();
        check("reset_done", 8'h01, 8'(reset_done));
        check("reset_busy", 8'h01, 8'(busy_seen));
        check("ready_again", 8'h00, 8'(dev_busy));
    endtask : t_first
    // Program sequence; the device only goes busy when not protected
    task automatic t_prog(input logic wp);
        write_protect_n = wp;
        busy_seen = 1'b0;
        send(OP_CMD, 8'h80);
        for (int i = 0; i < 5; i++) send(OP_ADDR, 8'(i));
        send(OP_WDATA, 8'hA5);
        send(OP_CMD, 8'h10, 1'b1);
        wait_rdy();
        check("wp_pin", 8'(wp), 8'(wp_n));
        check("prog_busy", 8'(wp), 8'(busy_seen));
    endtask : t_prog
    // Page read across the main/spare edge, plane bit set, reader stalled
    task automatic t_read;
        logic [7:0] adr[5] = '{8'hFE, 8'h07, 8'h40, 8'h00, 8'h00};
        int base;
        busy_seen = 1'b0;
        rd_ready = 1'b0;
        send(OP_CMD, 8'h00);
        foreach (adr[i]) send(OP_ADDR, adr[i]);
        send(OP_CMD, 8'h30, 1'b1);
        wait_rdy();
        check("read_busy", 8'h01, 8'(busy_seen));
        base = takes;
        req_wait_ready = 1'b0;
        req_kind = OP_RDATA;
        req_valid = 1'b1;
        step(300);
        check("fifo_fill", 8'h01, 8'(takes - base >= FIFO_DEPTH));
        check("none_out", 8'h00, 8'(got));
        rd_ready = 1'b1;
        wait_rdy();
        step(1);
        req_valid = 1'b0;
        step(100);
        check("drained", 8'(takes - base), 8'(got));
    endtask : t_read
    // Reset, then the scenarios in order
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 reset = 1'b0;
        t_first();
        t_prog(1'b0);
        t_prog(1'b1);
        t_read();
        end_sim();
    end
    // A hang counts as a mismatch
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
endmodule : nand_host_ctrl_tb_top
